// ==== rtl/tdpc_top.sv ====
// Purpose : touch dimmer controller, on/off, sweep and phase firing
// Assumes : one 100 MHz clock, all pins asynchronous to it
// Notes   : touch timing counts mains half waves so it scales with line
`timescale 1ns/1ns
`default_nettype none
module tdpc_top
  import tdpc_pkg::*;
#(
  parameter int unsigned RETAIN_CYC = RETAIN_CYC_DEF  // mains loss limit
)
(
  input  wire logic         CLOCK,
  input  wire logic         RST,
  input  wire logic         SYNC_IN,      // mains sync, high = positive
  input  wire logic         SENSOR_N,     // sensor, low = touched
  input  wire logic         EXT_IN,       // extension input
  input  wire logic         SLUMBER_CLK,  // slumber clock input
  input  wire logic [1:0]   VARIANT,      // behaviour strap
  output logic              TRIAC_FIRE,   // gate pulse
  output logic              LAMP_ON,      // lamp state
  output logic [LVL_W-1:0]  LEVEL,        // brightness memory
  output logic              DIMMING       // sweep running
);
  initial assert (RETAIN_CYC > 0) else $error("RETAIN_CYC must be nonzero");
  // --------------------------------------------------------------
  // input conditioning
  // --------------------------------------------------------------
  logic hw_tick;     // zero crossing pulse
  logic touch_raw;   // decoded touch per cycle
  logic slum_fall;   // slumber HL pulse
  tdpc_inp u_inp
  (
    .CLOCK      (CLOCK),
    .RST        (RST),
    .sync_pin   (SYNC_IN),
    .sens_n_pin (SENSOR_N),
    .ext_pin    (EXT_IN),
    .slum_pin   (SLUMBER_CLK),
    .hw_tick    (hw_tick),
    .touch_raw  (touch_raw),
    .slum_fall  (slum_fall)
  );
  // --------------------------------------------------------------
  // variant strap, synchronised in two stages
  // --------------------------------------------------------------
  logic [1:0] var1_r;
  logic [1:0] var2_r;
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      var1_r <= VAR_A;
      var2_r <= VAR_A;
    end
    else
    begin
      var1_r <= VARIANT;
      var2_r <= var1_r;
    end
  end
  wire var_b = (var2_r == VAR_B);
  wire var_c = (var2_r == VAR_C);
  // --------------------------------------------------------------
  // immunity filter, a change must hold for IMMUNE_HW half waves
  // --------------------------------------------------------------
  logic       touch_f_r;   // filtered touch
  logic [3:0] imm_r;       // half waves of disagreement
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      touch_f_r <= 1'b0;
      imm_r     <= 4'h0;
    end
    else if (hw_tick)
    begin
      // short glitches never reach the state machine
      if (touch_raw == touch_f_r)
        imm_r <= 4'h0;
      else if (imm_r == 4'(IMMUNE_HW - 1))
      begin
        touch_f_r <= touch_raw;
        imm_r     <= 4'h0;
      end
      else
        imm_r <= imm_r + 4'h1;
    end
  end
  // --------------------------------------------------------------
  // mains loss watchdog, counted on the system clock
  // --------------------------------------------------------------
  logic [31:0] gap_r;      // cycles since last crossing
  wire         lost = (gap_r == 32'(RETAIN_CYC));
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      gap_r <= 32'h00000000;
    else if (hw_tick)
      gap_r <= 32'h00000000;
    else if (!lost)
      gap_r <= gap_r + 32'h00000001;
  end
  // --------------------------------------------------------------
  // control state
  // --------------------------------------------------------------
  tdpc_state_t      st_r;
  tdpc_state_t      st_nxt;
  logic             lamp_r;     // lamp on
  logic             lamp_nxt;
  logic [LVL_W-1:0] lvl_r;      // brightness memory
  logic [LVL_W-1:0] lvl_nxt;
  logic             dir_r;      // 1 = brighter
  logic             dir_nxt;
  logic [5:0]       dur_r;      // half waves of touch
  logic [5:0]       dur_nxt;
  logic [6:0]       step_r;     // half waves within a step
  logic [6:0]       step_nxt;
  logic             pause_r;    // resting at minimum
  logic             pause_nxt;
  // --------------------------------------------------------------
  // decode of the current situation
  // --------------------------------------------------------------
  wire long_hit  = hw_tick && (dur_r == 6'(SHORT_MAX_HW - 1));
  wire step_end  = (step_r == 7'(STEP_HW - 1));
  wire pause_end = (step_r == 7'(PAUSE_HW - 1));
  wire at_max    = (lvl_r == LVL_MAX);
  wire at_min    = (lvl_r == LVL_MIN);
  // --------------------------------------------------------------
  // next state: touch length decides toggle or sweep
  // --------------------------------------------------------------
  always_comb
  begin
    st_nxt    = st_r;
    lamp_nxt  = lamp_r;
    lvl_nxt   = lvl_r;
    dir_nxt   = dir_r;
    dur_nxt   = dur_r;
    step_nxt  = step_r;
    pause_nxt = pause_r;
    if (lost)
    begin
      // too long without mains: come back dark
      st_nxt   = T_IDLE;
      lamp_nxt = 1'b0;
    end
    else
    begin
      case (st_r)
        T_IDLE:
        begin
          if (touch_f_r)
          begin
            st_nxt  = T_SHORT;
            dur_nxt = 6'h00;
          end
          else if (slum_fall && lamp_r)
          begin
            // slumber clock walks down, then switches off
            if (at_min)
              lamp_nxt = 1'b0;
            else
              lvl_nxt = lvl_r - 6'h01;
          end
        end
        T_SHORT:
        begin
          if (!touch_f_r)
          begin
            // toggle on release; filter guarantees the 50 ms floor
            st_nxt   = T_IDLE;
            lamp_nxt = !lamp_r;
            if (!lamp_r && !var_b)
              lvl_nxt = LVL_MAX;
          end
          else if (long_hit)
          begin
            // long touch: enter the sweep, lamp lights
            st_nxt    = T_DIM;
            lamp_nxt  = 1'b1;
            step_nxt  = 7'h00;
            pause_nxt = 1'b0;
            if (var_b)
              dir_nxt = !dir_r;
            else
            begin
              lvl_nxt = LVL_MIN;
              dir_nxt = var_c ? !dir_r : dir_r;
            end
          end
          else if (hw_tick)
            dur_nxt = dur_r + 6'h01;
        end
        T_DIM:
        begin
          if (!touch_f_r)
            st_nxt = T_IDLE;
          else if (hw_tick && pause_r)
          begin
            // rest at minimum, then climb again
            if (pause_end)
            begin
              pause_nxt = 1'b0;
              step_nxt  = 7'h00;
              dir_nxt   = 1'b1;
            end
            else
              step_nxt = step_r + 7'h01;
          end
          else if (hw_tick && step_end)
          begin
            step_nxt = 7'h00;
            if (dir_r)
            begin
              if (at_max)
                dir_nxt = 1'b0;
              else
                lvl_nxt = lvl_r + 6'h01;
            end
            else if (at_min)
              pause_nxt = 1'b1;
            else
              lvl_nxt = lvl_r - 6'h01;
          end
          else if (hw_tick)
            step_nxt = step_r + 7'h01;
        end
        default:
          st_nxt = T_IDLE;
      endcase
    end
  end
  // --------------------------------------------------------------
  // state registers
  // --------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      st_r    <= T_IDLE;
      lamp_r  <= 1'b0;
      lvl_r   <= LVL_MAX;
      dir_r   <= 1'b1;
      dur_r   <= 6'h00;
      step_r  <= 7'h00;
      pause_r <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      lamp_r  <= lamp_nxt;
      lvl_r   <= lvl_nxt;
      dir_r   <= dir_nxt;
      dur_r   <= dur_nxt;
      step_r  <= step_nxt;
      pause_r <= pause_nxt;
    end
  end
  // --------------------------------------------------------------
  // angle curve: square law makes brightness feel linear
  // --------------------------------------------------------------
  function automatic logic [7:0] cond_deg(input logic [LVL_W-1:0] l);
    int unsigned sq;
    sq = int'(l) * int'(l);
    return 8'(COND_MIN_DEG + (sq * (COND_MAX_DEG - COND_MIN_DEG)) / LVL_SQ_MAX);
  endfunction : cond_deg
  wire [7:0] cond     = cond_deg(lvl_r);
  wire [7:0] fire_deg = 8'(HALF_DEG) - cond;
  // --------------------------------------------------------------
  // firing stage, locked to the measured half wave
  // --------------------------------------------------------------
  tdpc_fire #(.PER_W(24)) u_fire
  (
    .CLOCK    (CLOCK),
    .RST      (RST),
    .hw_tick  (hw_tick),
    .enable   (lamp_r),
    .fire_deg (fire_deg),
    .fire     (TRIAC_FIRE)
  );
  assign LAMP_ON = lamp_r;
  assign LEVEL   = lvl_r;
  assign DIMMING = (st_r == T_DIM);
  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  wire release_short = (st_r == T_SHORT) && !touch_f_r && !lost;
  wire dim_entry     = (st_r == T_SHORT) && touch_f_r && long_hit && !lost;
  short_toggle_a: assert property (@(posedge CLOCK) disable iff (RST)
    release_short |=> lamp_r != $past(lamp_r) && st_r == T_IDLE)
    else $error("short touch did not toggle lamp");
  long_sweep_a: assert property (@(posedge CLOCK) disable iff (RST)
    dim_entry |=> st_r == T_DIM && lamp_r)
    else $error("long touch did not start sweep");
  var_a_entry_a: assert property (@(posedge CLOCK) disable iff (RST)
    dim_entry && var2_r == VAR_A |=> lvl_r == LVL_MIN && dir_r == $past(dir_r))
    else $error("variant A sweep start wrong");
  var_b_entry_a: assert property (@(posedge CLOCK) disable iff (RST)
    dim_entry && var_b |=> lvl_r == $past(lvl_r) && dir_r != $past(dir_r))
    else $error("variant B sweep start wrong");
  var_c_entry_a: assert property (@(posedge CLOCK) disable iff (RST)
    dim_entry && var_c |=> lvl_r == LVL_MIN && dir_r != $past(dir_r))
    else $error("variant C sweep start wrong");
  turn_on_max_a: assert property (@(posedge CLOCK) disable iff (RST)
    release_short && !lamp_r && !var_b |=> lvl_r == LVL_MAX)
    else $error("turn on did not select maximum");
  slumber_step_a: assert property (@(posedge CLOCK) disable iff (RST)
    st_r == T_IDLE && !touch_f_r && !lost && slum_fall && lamp_r && !at_min
    |=> lvl_r == $past(lvl_r) - 6'h01 && lamp_r)
    else $error("slumber edge did not step down");
  loss_off_a: assert property (@(posedge CLOCK) disable iff (RST)
    lost |=> !lamp_r ##1 !lamp_r)
    else $error("lamp stayed on after long mains loss");
  angle_range_a: assert property (@(posedge CLOCK) disable iff (RST)
    cond >= 8'(COND_MIN_DEG) && cond <= 8'(COND_MAX_DEG))
    else $error("conduction angle out of range");
  cover_toggle_c:  cover property (@(posedge CLOCK) disable iff (RST) release_short);
  cover_sweep_c:   cover property (@(posedge CLOCK) disable iff (RST) dim_entry);
  cover_pause_c:   cover property (@(posedge CLOCK) disable iff (RST) $rose(pause_r));
  cover_slumoff_c: cover property (@(posedge CLOCK) disable iff (RST)
    st_r == T_IDLE && slum_fall && lamp_r && at_min);
endmodule : tdpc_top
`default_nettype wire

// ==== include/tdpc_pkg.sv ====
// Purpose : constants shared by the touch dimmer phase controller
// Assumes : 100 MHz system clock, 50 Hz mains as the reference line
// Notes   : all touch timing counts mains half waves
package tdpc_pkg;
  // --------------------------------------------------------------
  // clock and mains reference
  // --------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 100;   // system clock rate
  localparam int unsigned HW_MS         = 10;    // half wave at 50 Hz
  localparam int unsigned TOUCH_MIN_MS  = 50;    // immunity period
  localparam int unsigned TOUCH_LONG_MS = 400;   // short/long border
  localparam int unsigned SWEEP_MS      = 7000;  // bright-dark-bright
  localparam int unsigned RETAIN_MS     = 1000;  // mains loss retention
  localparam int unsigned FIRE_US       = 10;    // triac gate pulse
  // --------------------------------------------------------------
  // derived counts
  // --------------------------------------------------------------
  localparam int unsigned IMMUNE_HW    = TOUCH_MIN_MS / HW_MS;
  localparam int unsigned SHORT_MAX_HW = TOUCH_LONG_MS / HW_MS;
  localparam int unsigned STEP_HW      = 5;     // half waves per step
  localparam int unsigned PAUSE_HW     = SWEEP_MS / HW_MS - 126 * STEP_HW;
  localparam int unsigned RETAIN_CYC_DEF = RETAIN_MS * 1000 * CLK_MHZ;
  localparam int unsigned FIRE_CYC     = FIRE_US * CLK_MHZ;
  // --------------------------------------------------------------
  // brightness and angle
  // --------------------------------------------------------------
  localparam int unsigned LVL_W        = 6;
  localparam logic [5:0]  LVL_MAX      = 6'h3F;
  localparam logic [5:0]  LVL_MIN      = 6'h00;
  localparam int unsigned COND_MIN_DEG = 35;
  localparam int unsigned COND_MAX_DEG = 152;
  localparam int unsigned HALF_DEG     = 180;
  localparam int unsigned LVL_SQ_MAX   = 63 * 63;
  // --------------------------------------------------------------
  // variants and states
  // --------------------------------------------------------------
  localparam logic [1:0]  VAR_A = 2'h0;  // on = max, same direction
  localparam logic [1:0]  VAR_B = 2'h1;  // restore level, reverse
  localparam logic [1:0]  VAR_C = 2'h2;  // on = max, reverse
  typedef enum logic [1:0]
  {
    T_IDLE  = 2'b00,
    T_SHORT = 2'b01,
    T_DIM   = 2'b10
  } tdpc_state_t;
endpackage : tdpc_pkg

// ==== rtl/tdpc_inp.sv ====
// Purpose : synchronise pins, find zero crossings, decode the inputs
// Assumes : sync pin high in the positive half wave
// Notes   : touch decode is settled once per full mains cycle
`timescale 1ns/1ns
`default_nettype none
module tdpc_inp
  import tdpc_pkg::*;
(
  input  wire logic CLOCK,
  input  wire logic RST,
  input  wire logic sync_pin,     // mains reference
  input  wire logic sens_n_pin,   // sensor, low = touched
  input  wire logic ext_pin,      // extension, high = operated
  input  wire logic slum_pin,     // slumber clock
  output logic      hw_tick,      // pulse at each zero crossing
  output logic      touch_raw,    // decoded touch, per cycle
  output logic      slum_fall     // pulse on slumber HL edge
);
  // --------------------------------------------------------------
  // two-stage synchronisers, stage one read by stage two only
  // --------------------------------------------------------------
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;               // previous value for edges
  logic       sens_seen_r;        // sensor low in positive half
  logic       ext_all_r;          // extension high all cycle
  logic       touch_r;
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      s3_r <= 4'h0;
    end
    else
    begin
      s1_r <= {slum_pin, ext_pin, sens_n_pin, sync_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // --------------------------------------------------------------
  // edge decode
  // --------------------------------------------------------------
  wire pos_half  = s2_r[0];
  wire rise      = s2_r[0] & ~s3_r[0];          // positive half starts
  assign hw_tick   = s2_r[0] ^ s3_r[0];
  assign slum_fall = ~s2_r[3] & s3_r[3];
  assign touch_raw = touch_r;
  // --------------------------------------------------------------
  // accumulate one full cycle, settle at the positive crossing
  // --------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      sens_seen_r <= 1'b0;
      ext_all_r   <= 1'b1;
      touch_r     <= 1'b0;
    end
    else if (rise)
    begin
      // both inputs act alike: either one operates the block
      touch_r     <= sens_seen_r | ext_all_r;
      sens_seen_r <= ~s2_r[1];
      ext_all_r   <= s2_r[2];
    end
    else
    begin
      sens_seen_r <= sens_seen_r | (pos_half & ~s2_r[1]);
      ext_all_r   <= ext_all_r & s2_r[2];
    end
  end
  decode_at_cross_a: assert property (@(posedge CLOCK) disable iff (RST)
    $changed(touch_r) |-> $past(rise))
    else $error("touch decode changed away from a crossing");
endmodule : tdpc_inp
`default_nettype wire

// ==== rtl/tdpc_fire.sv ====
// Purpose : place one triac gate pulse per half wave
// Assumes : hw_tick marks every zero crossing
// Notes   : degrees are counted by a fraction accumulator, no divider
`timescale 1ns/1ns
`default_nettype none
module tdpc_fire
  import tdpc_pkg::*;
#(
  parameter int unsigned PER_W = 24           // half wave period width
)
(
  input  wire logic       CLOCK,
  input  wire logic       RST,
  input  wire logic       hw_tick,
  input  wire logic       enable,       // lamp on, dropped by touch, slumber or long mains loss
  input  wire logic [7:0] fire_deg,     // delay after crossing
  output logic            fire          // gate pulse, from a flop
);
  initial assert (PER_W >= 22) else $error("PER_W too small for 50 Hz");
  logic [PER_W-1:0] cnt_r;    // cycles since crossing
  logic [PER_W-1:0] per_r;    // last half wave length
  logic [PER_W-1:0] acc_r;    // degree fraction
  logic [7:0]       deg_r;    // degrees since crossing
  logic             fired_r;  // one pulse per half wave
  logic             fire_r;
  logic [15:0]      len_r;    // pulse width counter
  // --------------------------------------------------------------
  // degree stepping: a degree passes each time acc crosses per
  // --------------------------------------------------------------
  wire [PER_W-1:0] acc_add = acc_r + PER_W'(HALF_DEG);
  wire             deg_up  = (per_r != '0) && (acc_add >= per_r);
  wire             hit     = enable && !fired_r && (deg_r == fire_deg);
  assign fire = fire_r;
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      cnt_r <= '0;
      per_r <= '0;
      acc_r <= '0;
      deg_r <= 8'h00;
    end
    else if (hw_tick)
    begin
      // re-measure each half wave so timing follows line frequency
      per_r <= cnt_r;
      cnt_r <= '0;
      acc_r <= '0;
      deg_r <= 8'h00;
    end
    else
    begin
      cnt_r <= (cnt_r == '1) ? cnt_r : cnt_r + 1'b1;
      acc_r <= deg_up ? acc_add - per_r : acc_add;
      deg_r <= (deg_up && deg_r != 8'hFF) ? deg_r + 8'h01 : deg_r;
    end
  end
  // --------------------------------------------------------------
  // gate pulse, cut short by the next crossing
  // --------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      fired_r <= 1'b0;
      fire_r  <= 1'b0;
      len_r   <= 16'h0000;
    end
    else if (hw_tick)
    begin
      fired_r <= 1'b0;
      fire_r  <= 1'b0;
    end
    else if (hit)
    begin
      fired_r <= 1'b1;
      fire_r  <= 1'b1;
      len_r   <= 16'(FIRE_CYC - 1);
    end
    else if (fire_r)
    begin
      fire_r <= (len_r != 16'h0000);
      len_r  <= len_r - 16'h0001;
    end
  end
  tick_ends_pulse_a: assert property (@(posedge CLOCK) disable iff (RST)
    hw_tick |=> !fire_r)
    else $error("gate pulse crossed a zero crossing");
  // a new pulse may only start from a half wave that has not fired yet
  one_pulse_half_a: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(fire_r) |-> !$past(fired_r))
    else $error("second gate pulse in one half wave");
endmodule : tdpc_fire
`default_nettype wire

// ==== tb/tdpc_mains.sv ====
// Purpose : mains sync, sensor and extension model for the dimmer bench
// Assumes : half wave of HW clock cycles while run is high
// Notes   : sync rests low while mains is lost
`timescale 1ns/1ns
`default_nettype none
module tdpc_mains
#(
  parameter int HW = 200                 // half wave length in cycles
)
(
  input  wire logic CLOCK,
  input  wire logic run,                 // mains present
  input  wire logic tch_s,               // finger on sensor
  input  wire logic tch_e,               // extension button held
  output var logic  SYNC_IN,
  output logic      SENSOR_N,
  output logic      EXT_IN
);
  int cnt = 0;                           // cycles into the half wave
  initial SYNC_IN = 1'b0;
  // --------------------------------------------------------------
  // mains phase, changed on the falling edge like all bench drive
  // --------------------------------------------------------------
  always @(negedge CLOCK)
  begin
    cnt <= (cnt == HW - 1 || !run) ? 0 : cnt + 1;
    if (!run)
      SYNC_IN <= 1'b0;
    else if (cnt == HW - 1)
      SYNC_IN <= ~SYNC_IN;
  end
  // sensor is low in the negative half as a trap: only positive half counts
  assign SENSOR_N = SYNC_IN ? ~tch_s : 1'b0;
  // idle extension is high in the positive half, so a whole-cycle test is needed
  assign EXT_IN = tch_e | SYNC_IN;
endmodule : tdpc_mains
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose : self-checking bench for the touch dimmer controller
// Assumes : short mains half wave, so touch timing runs fast
// Notes   : expectations are worked out from half wave counts
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import tdpc_pkg::*;
  localparam int HW = 200;               // half wave in clock cycles
  logic       clk = 1'b0, rst = 1'b1, slum = 1'b0, run = 1'b1, tch_s = 1'b0, tch_e = 1'b0;
  logic [1:0] variant = 2'h1;            // start in the restoring variant
  logic       sync_in, sens_n, ext_in, fire, lamp, dim;
  logic [5:0] level;
  int         n_fail = 0, n_compared = 0, cyc = 0, n_pulse = 0, d;
  integer     seed = 32'h673A;
  initial forever #5 clk = ~clk;
  tdpc_mains #(.HW(HW)) MAINS (.CLOCK(clk), .run(run), .tch_s(tch_s), .tch_e(tch_e),
    .SYNC_IN(sync_in), .SENSOR_N(sens_n), .EXT_IN(ext_in));
  tdpc_top #(.RETAIN_CYC(4000)) DUT (.CLOCK(clk), .RST(rst), .SYNC_IN(sync_in),
    .SENSOR_N(sens_n), .EXT_IN(ext_in), .SLUMBER_CLK(slum), .VARIANT(variant),
    .TRIAC_FIRE(fire), .LAMP_ON(lamp), .LEVEL(level), .DIMMING(dim));
  always @(posedge fire) n_pulse++;
  // hang guard, above the at most roughly 72k cycles the sequence needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic hw(input int n);
    repeat (n * HW) @(negedge clk);
  endtask : hw
  function automatic int rnd(input int lo, input int hi);
    return lo + int'($unsigned($random(seed)) % (hi - lo + 1));
  endfunction : rnd
  // crossing seen 3 edges late, then 180 minus conduction degrees
  function automatic int exp_dly(input int lv);
    return 3 + (180 - (35 + lv * lv * 117 / 3969)) * HW / 180;
  endfunction : exp_dly
  // short touch on either input, then let the filter settle
  task automatic touch(input logic ext);
    if (ext)
      tch_e = 1'b1;
    else
      tch_s = 1'b1;
    hw(rnd(12, 25));
    tch_s = 1'b0;
    tch_e = 1'b0;
    hw(15);
  endtask : touch
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    chk({lamp, dim, level}, 8'h3F, "reset state");
    hw(4);
    chk(8'(n_pulse), 8'h00, "fire while off");
    tch_s = 1'b1;
    hw(rnd(1, 2));
    tch_s = 1'b0;
    hw(15);
    chk({7'h00, lamp}, 8'h00, "glitch");
    tch_s = 1'b1;
    hw(rnd(12, 25));
    chk({7'h00, lamp}, 8'h00, "toggle before release");
    tch_s = 1'b0;
    hw(15);
    chk({lamp, dim, level}, 8'hBF, "short touch on");
    n_pulse = 0;
    hw(10);
    chk({7'h00, n_pulse inside {[9:11]}}, 8'h01, "pulse count");
    @(posedge sync_in);
    d = 0;
    // the previous pulse outlasts the short bench half wave: let the crossing cut it first
    while (fire === 1'b1 && d < HW)
    begin
      @(negedge clk);
      d++;
    end
    while (fire !== 1'b1 && d < HW)
    begin
      @(negedge clk);
      d++;
    end
    chk({7'h00, d >= exp_dly(63) - 6 && d <= exp_dly(63) + 6}, 8'h01, "fire delay");
    slum = 1'b1;
    hw(1);
    slum = 1'b0;
    hw(1);
    chk({lamp, dim, level}, 8'hBE, "slumber step");
    touch(1'b1);
    chk({lamp, dim, level}, 8'h3E, "extension off");
    touch(1'b0);
    chk({lamp, dim, level}, 8'hBE, "restored level");
    run = 1'b0;
    repeat (2000) @(negedge clk);
    run = 1'b1;
    hw(4);
    chk({7'h00, lamp}, 8'h01, "short mains gap");
    run = 1'b0;
    repeat (6000) @(negedge clk);
    run = 1'b1;
    hw(4);
    chk({lamp, dim, level}, 8'h3E, "long mains loss");
    variant = 2'h2;
    tch_s = 1'b1;
    hw(60);
    chk({lamp, dim, level}, 8'hC0, "dim from minimum");
    tch_s = 1'b0;
    hw(15);
    chk({lamp, dim, level}, 8'h80, "sweep ends");
    variant = 2'h0;
    touch(1'b0);
    touch(1'b1);
    chk({lamp, dim, level}, 8'hBF, "on at maximum");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
